// file: hw/seep_pkg.sv
// Purpose: Shared constants for the serial EEPROM command port
// Assumes: Core clock of 20 MHz, 512 x 8 array, 4-byte pages
// Notes:   Times are typical figures; cycle counts derive from CLK_KHZ
package seep_pkg;

   // Core clock rate
   localparam int CLK_KHZ = 20000;

   // Times in milliseconds and their core-clock counts
   localparam int WDOG_T0_MS     = 1400;
   localparam int WDOG_T1_MS     = 600;
   localparam int WDOG_T2_MS     = 200;
   localparam int WR_CYC_MS      = 10;
   localparam int RST_HOLD_MS    = 200;
   localparam int WDOG_T0_CYC    = WDOG_T0_MS * CLK_KHZ;
   localparam int WDOG_T1_CYC    = WDOG_T1_MS * CLK_KHZ;
   localparam int WDOG_T2_CYC    = WDOG_T2_MS * CLK_KHZ;
   localparam int WR_CYC_CYC     = WR_CYC_MS * CLK_KHZ;
   localparam int RST_HOLD_CYC   = RST_HOLD_MS * CLK_KHZ;

   // Array geometry
   localparam int AW             = 9;
   localparam int MEM_BYTES      = 512;
   localparam int PAGE_BYTES     = 4;

   // Opcodes
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_STAT_RD   = 8'h05;
   localparam logic [7:0] OP_STAT_WR   = 8'h01;
   localparam logic [7:0] OP_ARR_MASK  = 8'hF7;
   localparam logic [7:0] OP_ARR_RD    = 8'h03;
   localparam logic [7:0] OP_ARR_WR    = 8'h02;
   localparam int         OP_MSB_BIT   = 3;

   // Bit counts at the link
   localparam logic [6:0] CNT_ONE      = 7'h01;
   localparam logic [6:0] CNT_OP       = 7'h08;
   localparam logic [6:0] CNT_ADDR     = 7'h10;
   localparam logic [6:0] CNT_WR_MIN   = 7'h18;
   localparam logic [6:0] CNT_WR_MAX   = 7'h30;
   localparam logic [6:0] CNT_SAT      = 7'h7F;

   // Status layout
   localparam int         ST_WIP       = 0;
   localparam int         ST_WEL       = 1;
   localparam int         ST_BP_LO     = 2;
   localparam int         ST_WD_LO     = 4;
   localparam logic [7:0] STAT_BUSY    = 8'hFF;
   localparam logic [1:0] WD_SEL_OFF   = 2'h3;
   localparam logic [1:0] WD_SEL_T1    = 2'h1;
   localparam logic [1:0] WD_SEL_T2    = 2'h2;
   localparam logic [1:0] NV_RST       = 2'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} seep_state_t;

   function automatic logic op_is_read(input logic [7:0] op);
      op_is_read = (op & OP_ARR_MASK) == OP_ARR_RD;
   endfunction : op_is_read

   function automatic logic op_is_write(input logic [7:0] op);
      op_is_write = (op & OP_ARR_MASK) == OP_ARR_WR;
   endfunction : op_is_write

endpackage : seep_pkg

// file: hw/seep_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Inputs are levels or quasi-static words
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module seep_sync #(
   parameter int W = 1
) (
   // Clock
   input  wire logic         clk,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end

endmodule : seep_sync

// file: hw/seep_wdog.sv
// Purpose: Watchdog timer restarted by chip select falling edges
// Assumes: Restart is a one-cycle pulse in the core domain
// Notes:   Expiry is a one-cycle pulse; counting restarts after expiry
`timescale 1ns/10ps
module seep_wdog #(
   parameter int T0_CYC = seep_pkg::WDOG_T0_CYC,
   parameter int T1_CYC = seep_pkg::WDOG_T1_CYC,
   parameter int T2_CYC = seep_pkg::WDOG_T2_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Control
   input  wire logic       restart,
   input  wire logic [1:0] sel,
   // Event
   output logic            expire_q
);
   logic [31:0] cnt_q;
   wire  [31:0] lim;
   wire         off;

   // Period select
   assign lim = (sel == seep_pkg::WD_SEL_T1) ? 32'(T1_CYC - 1) :
                (sel == seep_pkg::WD_SEL_T2) ? 32'(T2_CYC - 1) :
                32'(T0_CYC - 1);
   assign off = sel == seep_pkg::WD_SEL_OFF;

   always_ff @(posedge clk) begin
      if (srst || restart || off) begin
         cnt_q    <= 32'h0000_0000;
         expire_q <= 1'b0;
      end else if (cnt_q == lim) begin
         cnt_q    <= 32'h0000_0000;
         expire_q <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 32'h0000_0001;
         expire_q <= 1'b0;
      end
   end

endmodule : seep_wdog

// file: hw/seep_port.sv
// Purpose: Serial command port of a 512 x 8 EEPROM with supervisory reset
// Assumes: spi_sck stops while chip select is high; core clock 20 MHz
// Notes:   Array lives here; link logic reads it, core logic writes it
`timescale 1ns/10ps
module seep_port #(
   parameter int   WR_CYC        = seep_pkg::WR_CYC_CYC,
   parameter int   RST_HOLD_CYC  = seep_pkg::RST_HOLD_CYC,
   parameter int   WDOG_T0_CYC   = seep_pkg::WDOG_T0_CYC,
   parameter int   WDOG_T1_CYC   = seep_pkg::WDOG_T1_CYC,
   parameter int   WDOG_T2_CYC   = seep_pkg::WDOG_T2_CYC,
   parameter logic RST_ACT_HIGH  = 1'b0
) (
   // Core clock and reset
   input  wire logic core_clk,
   input  wire logic srst,
   // Serial link
   input  wire logic spi_sck,
   input  wire logic spi_cs_n,
   input  wire logic spi_si,
   output logic      spi_so,
   output logic      spi_so_oe_n,
   // Protection and supervision
   input  wire logic wp_n,
   input  wire logic vlow_det,
   output logic      rst_out
);

   // Array, written only from the core domain
   logic [7:0] mem [seep_pkg::MEM_BYTES];

   // ---------------- Link domain ----------------
   logic       frame_act_q;
   logic       tx_act_q;
   logic [6:0] lk_cnt_q;
   logic [7:0] sh_q;
   logic [7:0] opcode_q;
   logic [8:0] addr_q;
   logic [8:0] rd_ptr_q;
   logic [7:0] tx_q;
   logic [1:0] wr_lo_q;
   logic [3:0] mask_q;
   logic [7:0] page_q [seep_pkg::PAGE_BYTES];
   logic       armed_s;
   logic [7:0] stat_s;

   // Core-side state seen by the link
   logic       armed_q;
   logic [7:0] stat_q;

   wire        link_clr;
   wire  [6:0] cnt_nx;
   wire  [7:0] byte_now;
   wire        byte_end;
   wire        at_op;
   wire        at_addr;
   wire        past_op;
   wire        past_addr;
   wire  [8:0] addr_now;
   wire        rd_cmd;
   wire        wr_cmd;
   wire        st_rd_now;
   wire        st_rd_more;
   wire        rd_first;
   wire        rd_more;
   wire        pg_load;

   // Reset also parks the output so it is off before any frame
   assign link_clr   = spi_cs_n | srst;
   assign cnt_nx     = !frame_act_q ? seep_pkg::CNT_ONE :
                       (lk_cnt_q == seep_pkg::CNT_SAT) ? seep_pkg::CNT_SAT :
                       lk_cnt_q + seep_pkg::CNT_ONE;
   assign byte_now   = {sh_q[6:0], spi_si};
   assign byte_end   = cnt_nx[2:0] == 3'h0;
   assign at_op      = byte_end && (cnt_nx == seep_pkg::CNT_OP);
   assign at_addr    = byte_end && (cnt_nx == seep_pkg::CNT_ADDR);
   assign past_op    = byte_end && (cnt_nx > seep_pkg::CNT_OP);
   assign past_addr  = byte_end && (cnt_nx > seep_pkg::CNT_ADDR);
   assign addr_now   = {opcode_q[seep_pkg::OP_MSB_BIT], byte_now};
   assign rd_cmd     = seep_pkg::op_is_read(opcode_q);
   assign wr_cmd     = seep_pkg::op_is_write(opcode_q);
   assign st_rd_now  = at_op && (byte_now == seep_pkg::OP_STAT_RD);
   assign st_rd_more = past_op && (opcode_q == seep_pkg::OP_STAT_RD);
   assign rd_first   = at_addr && rd_cmd;
   assign rd_more    = past_addr && rd_cmd;
   assign pg_load    = past_addr && wr_cmd;

   // Frame marker; cleared by chip select so each frame restarts counting
   always_ff @(posedge spi_sck or posedge link_clr) begin
      if (link_clr) begin
         frame_act_q <= 1'b0;
         tx_act_q    <= 1'b0;
      end else begin
         frame_act_q <= 1'b1;
         if ((st_rd_now || rd_first) && armed_s) begin
            tx_act_q <= 1'b1;
         end
      end
   end

   // Input shifting on rising edges; kept after the frame for the core
   always_ff @(posedge spi_sck) begin
      lk_cnt_q <= cnt_nx;
      sh_q     <= byte_now;
      if (at_op) begin
         opcode_q <= byte_now;
      end
      if (at_addr) begin
         addr_q  <= addr_now;
         wr_lo_q <= byte_now[1:0];
         mask_q  <= 4'h0;
      end
      if (pg_load) begin
         page_q[wr_lo_q] <= byte_now;
         mask_q[wr_lo_q] <= 1'b1;
         wr_lo_q         <= wr_lo_q + 2'h1;
      end
   end

   // Output byte selection
   always_ff @(posedge spi_sck) begin
      if (st_rd_now || st_rd_more) begin
         tx_q <= stat_s;
      end else if (rd_first) begin
         tx_q     <= mem[addr_now];
         rd_ptr_q <= addr_now + 9'h001;
      end else if (rd_more) begin
         tx_q     <= mem[rd_ptr_q];
         rd_ptr_q <= rd_ptr_q + 9'h001;
      end
   end

   // Output changes on falling edges, MSB first
   always_ff @(negedge spi_sck or posedge link_clr) begin
      if (link_clr) begin
         spi_so      <= 1'b0;
         spi_so_oe_n <= 1'b1;
      end else begin
         spi_so      <= tx_q[~lk_cnt_q[2:0]];
         spi_so_oe_n <= ~tx_act_q;
      end
   end

   // Status and arming into the link domain
   seep_sync #(.W(9)) u_lk_sync (
      .clk (spi_sck),
      .d   ({armed_q, stat_q}),
      .q   ({armed_s, stat_s})
   );

   // ---------------- Core domain ----------------
   logic                  cs_s;
   logic                  wp_s;
   logic                  vlow_s;
   logic                  cs_d_q;
   logic                  wel_q;
   logic [1:0]            wd_sel_q;
   logic [1:0]            bp_q;
   logic [1:0]            pidx_q;
   logic [31:0]           wc_q;
   logic [31:0]           hold_q;
   logic                  wd_exp;
   seep_pkg::seep_state_t state_q;

   wire        cs_rise;
   wire        cs_fall;
   wire        go;
   wire        wr_cnt_ok;
   wire        do_set;
   wire        do_clr;
   wire        do_arr;
   wire        do_stw;
   wire        prog_we;
   wire        wait_done;
   wire        rst_act;
   wire  [8:0] prog_addr;

   seep_sync #(.W(3)) u_core_sync (
      .clk (core_clk),
      .d   ({spi_cs_n, wp_n, vlow_det}),
      .q   ({cs_s, wp_s, vlow_s})
   );

   // Link words are stable here: the link clock has stopped by cs_rise
   assign cs_rise   = cs_s & ~cs_d_q;
   assign cs_fall   = ~cs_s & cs_d_q;
   assign go        = cs_rise && armed_q && (state_q == seep_pkg::ST_IDLE);
   assign wr_cnt_ok = (lk_cnt_q[2:0] == 3'h0) &&
                      (lk_cnt_q >= seep_pkg::CNT_WR_MIN) &&
                      (lk_cnt_q <= seep_pkg::CNT_WR_MAX);
   assign do_set    = go && (opcode_q == seep_pkg::OP_LATCH_SET) &&
                      (lk_cnt_q == seep_pkg::CNT_OP);
   assign do_clr    = go && (opcode_q == seep_pkg::OP_LATCH_CLR) &&
                      (lk_cnt_q == seep_pkg::CNT_OP);
   assign do_arr    = go && wel_q && wp_s && wr_cmd && wr_cnt_ok;
   assign do_stw    = go && wel_q && wp_s &&
                      (opcode_q == seep_pkg::OP_STAT_WR) &&
                      (lk_cnt_q == seep_pkg::CNT_ADDR);
   assign prog_we   = (state_q == seep_pkg::ST_PROG) && mask_q[pidx_q];
   assign prog_addr = {addr_q[8:2], pidx_q};
   assign wait_done = (state_q == seep_pkg::ST_WAIT) && (wc_q == 32'(WR_CYC - 1));
   assign rst_act   = vlow_s || (hold_q != 32'h0000_0000);

   // Edge history and arming after reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cs_d_q  <= 1'b1;
         armed_q <= 1'b0;
      end else begin
         cs_d_q <= cs_s;
         if (cs_s) begin
            armed_q <= 1'b1;
         end
      end
   end

   // Write latch; clears take priority for safety
   always_ff @(posedge core_clk) begin
      if (srst || !wp_s) begin
         wel_q <= 1'b0;
      end else if (wait_done || do_clr) begin
         wel_q <= 1'b0;
      end else if (do_set) begin
         wel_q <= 1'b1;
      end
   end

   // Protection and watchdog settings
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wd_sel_q <= seep_pkg::NV_RST;
         bp_q     <= seep_pkg::NV_RST;
      end else if (do_stw) begin
         wd_sel_q <= addr_q[seep_pkg::ST_WD_LO +: 2];
         bp_q     <= addr_q[seep_pkg::ST_BP_LO +: 2];
      end
   end

   // Write cycle sequencer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= seep_pkg::ST_IDLE;
         pidx_q  <= 2'h0;
         wc_q    <= 32'h0000_0000;
      end else begin
         case (state_q)
            seep_pkg::ST_IDLE: begin
               pidx_q <= 2'h0;
               wc_q   <= 32'h0000_0000;
               if (do_arr) begin
                  state_q <= seep_pkg::ST_PROG;
               end else if (do_stw) begin
                  state_q <= seep_pkg::ST_WAIT;
               end
            end
            seep_pkg::ST_PROG: begin
               pidx_q <= pidx_q + 2'h1;
               if (pidx_q == 2'h3) begin
                  state_q <= seep_pkg::ST_WAIT;
               end
            end
            seep_pkg::ST_WAIT: begin
               wc_q <= wc_q + 32'h0000_0001;
               if (wait_done) begin
                  state_q <= seep_pkg::ST_IDLE;
               end
            end
            default: state_q <= seep_pkg::ST_IDLE;
         endcase
      end
   end

   // Only loaded page bytes are programmed
   always_ff @(posedge core_clk) begin
      if (prog_we) begin
         mem[prog_addr] <= page_q[pidx_q];
      end
   end

   // Status image; all ones while busy
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stat_q <= 8'h00;
      end else if (state_q != seep_pkg::ST_IDLE) begin
         stat_q <= seep_pkg::STAT_BUSY;
      end else begin
         stat_q <= {2'h0, wd_sel_q, bp_q, wel_q, 1'b0};
      end
   end

   // Watchdog
   seep_wdog #(
      .T0_CYC (WDOG_T0_CYC),
      .T1_CYC (WDOG_T1_CYC),
      .T2_CYC (WDOG_T2_CYC)
   ) u_wdog (
      .clk      (core_clk),
      .srst     (srst),
      .restart  (cs_fall),
      .sel      (wd_sel_q),
      .expire_q (wd_exp)
   );

   // Reset output stretch; held after supply returns or timeout fires
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hold_q  <= 32'h0000_0000;
         rst_out <= RST_ACT_HIGH;
      end else begin
         if (vlow_s || wd_exp) begin
            hold_q <= 32'(RST_HOLD_CYC);
         end else if (hold_q != 32'h0000_0000) begin
            hold_q <= hold_q - 32'h0000_0001;
         end
         rst_out <= rst_act ? RST_ACT_HIGH : ~RST_ACT_HIGH;
      end
   end

endmodule : seep_port

// file: tb/seep_port_sva.sv
// Purpose: Port checks for the serial command port
// Assumes: Core clock domain; link checks clocked by the link clock
// Notes:   Watchdog bound uses the shortest period only
`timescale 1ns/10ps
module seep_port_chk #(
   parameter int   RST_HOLD_CYC = 10,
   parameter int   WDOG_T2_CYC  = 100,
   parameter logic RST_ACT_HIGH = 1'b0
) (
   // Core
   input wire logic core_clk,
   input wire logic srst,
   // Link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe_n,
   // Supervision
   input wire logic wp_n,
   input wire logic vlow_det,
   input wire logic rst_out
);
   localparam int REL_MIN = RST_HOLD_CYC;
   localparam int REL_MAX = RST_HOLD_CYC + 8;
   logic [5:0] bit_q;
   logic [7:0] op_q;
   int         idle_q;
   wire        rst_act = (rst_out == RST_ACT_HIGH);

   // Bit count and opcode of the frame
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         bit_q <= 6'h00;
         op_q  <= 8'h00;
      end else begin
         if (bit_q != 6'h3F) bit_q <= bit_q + 6'h01;
         if (bit_q < 6'h08) op_q <= {op_q[6:0], spi_si};
      end
   end

   // Raw select edge: the design restarts later, never earlier
   always_ff @(posedge core_clk) begin
      if (srst || $fell(spi_cs_n)) idle_q <= 0;
      else if (idle_q < 1000000) idle_q <= idle_q + 1;
   end

   chk_oe_desel: assert property (@(posedge core_clk) disable iff (srst)
      spi_cs_n |-> spi_so_oe_n) else $error("output on while deselected");
   chk_srst_out: assert property (@(posedge core_clk)
      srst |=> rst_act && spi_so_oe_n) else $error("reset state wrong");
   chk_rel_srst: assert property (@(posedge core_clk) disable iff (srst)
      $fell(srst) && !vlow_det |=> !rst_act) else $error("reset out stuck");
   chk_vlow_on: assert property (@(posedge core_clk) disable iff (srst)
      vlow_det |-> ##[1:4] rst_act) else $error("low supply ignored");
   chk_pulse_len: assert property (@(posedge core_clk) disable iff (srst)
      $rose(rst_act) |-> rst_act[*8]) else $error("reset pulse short");
   chk_hold_end: assert property (@(posedge core_clk) disable iff (srst)
      $fell(vlow_det) |-> rst_act ##[REL_MIN:REL_MAX] !rst_act) else $error("hold wrong");
   chk_wdog_min: assert property (@(posedge core_clk) disable iff (srst)
      $rose(rst_act) && !vlow_det |-> idle_q >= WDOG_T2_CYC) else $error("watchdog early");
   chk_op_quiet: assert property (@(posedge spi_sck) disable iff (srst)
      bit_q < 6'h08 |-> spi_so_oe_n) else $error("output during opcode");
   chk_stat_out: assert property (@(posedge spi_sck) disable iff (srst)
      bit_q == 6'h08 && op_q == 8'h05 |-> !spi_so_oe_n) else $error("no status out");
   chk_read_out: assert property (@(posedge spi_sck) disable iff (srst)
      bit_q == 6'h10 && (op_q & 8'hF7) == 8'h03 |-> !spi_so_oe_n) else $error("no read out");
   chk_other_quiet: assert property (@(posedge spi_sck) disable iff (srst)
      bit_q >= 6'h08 && op_q != 8'h05 && (op_q & 8'hF7) != 8'h03 |-> spi_so_oe_n)
      else $error("output on other command");
endmodule : seep_port_chk

bind seep_port seep_port_chk #(.RST_HOLD_CYC(RST_HOLD_CYC), .WDOG_T2_CYC(WDOG_T2_CYC),
   .RST_ACT_HIGH(RST_ACT_HIGH)) i_chk (.core_clk(core_clk), .srst(srst), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
   .wp_n(wp_n), .vlow_det(vlow_det), .rst_out(rst_out));

// file: tb/seep_host.sv
// Purpose: Host master model driving the serial link
// Assumes: Link clock period 30 ns, clock low between frames
// Notes:   Data line shows the inverse of its last bit when idle
`timescale 1ns/10ps
module seep_host (
   // Link
   output logic        spi_sck,
   output logic        spi_cs_n,
   output logic        spi_si,
   input  wire logic   spi_so,
   // Frame result
   output logic [31:0] rx_word,
   output logic        rx_stb
);
   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
      rx_word  = 32'h0000_0000;
      rx_stb   = 1'b0;
   end

   // Low nb bits of tx, top one first; select rises after the last fall
   task automatic xfer(input logic [63:0] tx, input int nb, input logic post);
      logic [31:0] rx;
      rx       = 32'h0000_0000;
      spi_cs_n = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         spi_si = tx[i];
         #15;
         spi_sck = 1'b1;
         rx      = {rx[30:0], spi_so};
         #15;
         spi_sck = 1'b0;
      end
      #15;
      spi_cs_n = 1'b1;
      spi_si   = ~spi_si;
      rx_word  = rx;
      if (post) rx_stb = ~rx_stb;
   endtask : xfer
endmodule : seep_host

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the serial command port
// Assumes: Shortened write, hold and watchdog counts
// Notes:   Frame results are compared in arrival order
`timescale 1ns/10ps
module tb_top;
   localparam int WR_CYC = 20;
   localparam int HOLD   = 10;

   logic        core_clk;
   logic        srst;
   logic        wp_n;
   logic        vlow_det;
   wire         spi_sck;
   wire         spi_cs_n;
   wire         spi_si;
   wire         spi_so;
   wire         spi_so_oe_n;
   wire         so_line;
   wire         rst_out;
   wire  [31:0] rx_word;
   wire         rx_stb;
   logic [7:0]  mem [0:511];
   logic [63:0] exp_q [$];
   logic [63:0] nt;
   logic [31:0] rnd;
   logic [7:0]  sb;
   int          wd [4] = '{400, 200, 100, 600};
   int          bad [5] = '{16, 25, 31, 39, 49};
   int          k;
   int          miscompares;
   int          n_tests;

   seep_port #(.WR_CYC(WR_CYC), .RST_HOLD_CYC(HOLD), .WDOG_T0_CYC(400), .WDOG_T1_CYC(200),
      .WDOG_T2_CYC(100), .RST_ACT_HIGH(1'b0)) i_dut (.core_clk(core_clk), .srst(srst),
      .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
      .spi_so_oe_n(spi_so_oe_n), .wp_n(wp_n), .vlow_det(vlow_det), .rst_out(rst_out));
   // Released line shows the inverse, so a late output enable corrupts the data
   assign so_line = spi_so_oe_n ? ~spi_so : spi_so;
   seep_host i_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(so_line), .rx_word(rx_word), .rx_stb(rx_stb));

   always #25 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      // A result that never arrived counts as a mismatch
      if (exp_q.size() != 0) miscompares++;
      $display("checks=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // Gap kept short so a status read still lands inside the write cycle
   task automatic frame(input logic [63:0] tx, input int nb, input logic post);
      @(negedge core_clk);
      #7;
      i_host.xfer(tx, nb, post);
      rnd = xs(rnd);
      repeat (10 + rnd[1:0]) @(negedge core_clk);
   endtask : frame

   task automatic st_rd(input logic [7:0] v);
      exp_q.push_back({32'h0000_00FF, 24'h0, v});
      frame(64'h0500, 16, 1'b1);
   endtask : st_rd

   task automatic rd(input logic [8:0] a, input int n);
      logic [31:0] e;
      logic [63:0] m;
      logic [63:0] tx;
      e = 32'h0;
      for (int i = 0; i < n; i++) e = {e[23:0], mem[a + i[8:0]]};
      m = (64'h1 << (8 * n)) - 64'h1;
      exp_q.push_back({m[31:0], e});
      tx = {56'h0, 4'h0, a[8], 3'b011};
      frame(((tx << 8) | a[7:0]) << (8 * n), 16 + 8 * n, 1'b1);
   endtask : rd

   task automatic wr(input logic [8:0] a, input int n);
      logic [63:0] tx;
      tx = {56'h0, 4'h0, a[8], 3'b010};
      tx = (tx << 8) | a[7:0];
      for (int i = 0; i < n; i++) begin
         rnd = xs(rnd);
         tx  = (tx << 8) | rnd[7:0];
         mem[{a[8:2], a[1:0] + i[1:0]}] = rnd[7:0];
      end
      frame(64'h06, 8, 1'b0);
      frame(tx, 16 + 8 * n, 1'b0);
      st_rd(8'hFF);
      repeat (WR_CYC + 10) @(negedge core_clk);
      st_rd(8'h00);
   endtask : wr

   initial begin
      #1;
      forever begin
         @(rx_stb);
         nt = exp_q.pop_front();
         chk(rx_word & nt[63:32], nt[31:0]);
      end
   end

   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end

   initial begin
      core_clk    = 1'b0;
      srst        = 1'b1;
      wp_n        = 1'b1;
      vlow_det    = 1'b0;
      rnd         = 32'h0000_A3F6;
      miscompares = 0;
      n_tests     = 0;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({31'h0, rst_out}, 32'h1);
      chk({31'h0, spi_so_oe_n}, 32'h1);
      repeat (5) @(negedge core_clk);
      st_rd(8'h00);
      frame(64'h06, 8, 1'b0);
      st_rd(8'h02);
      frame(64'h04, 8, 1'b0);
      st_rd(8'h00);
      frame(64'h0C, 9, 1'b0);
      st_rd(8'h00);
      wr(9'h000, 2);
      wr(9'h1FE, 4);
      rd(9'h1FF, 3);
      rd(9'h1FC, 4);
      foreach (bad[i]) begin
         frame(64'h06, 8, 1'b0);
         frame(64'h0210_A5A5_A5A5_A5A5 >> (64 - bad[i]), bad[i], 1'b0);
         st_rd(8'h02);
      end
      wp_n = 1'b0;
      repeat (5) @(negedge core_clk);
      st_rd(8'h00);
      frame(64'h06, 8, 1'b0);
      frame(64'h02_20_77, 24, 1'b0);
      st_rd(8'h00);
      wp_n = 1'b1;
      for (int s = 0; s < 4; s++) begin
         sb = {2'b00, s[1:0], s[1:0], 2'b00};
         frame(64'h06, 8, 1'b0);
         frame({48'h0, 8'h01, sb}, 16, 1'b0);
         st_rd(8'hFF);
         repeat (WR_CYC + 10) @(negedge core_clk);
         st_rd(sb);
         k = 0;
         while (rst_out === 1'b1 && k < 600) begin
            @(negedge core_clk);
            k++;
         end
         chk({31'h0, k >= wd[s] - 30 && k <= wd[s] + 5}, 32'h1);
         repeat (HOLD + 5) @(negedge core_clk);
      end
      vlow_det = 1'b1;
      repeat (5) @(negedge core_clk);
      chk({31'h0, rst_out}, 32'h0);
      vlow_det = 1'b0;
      repeat (HOLD + 8) @(negedge core_clk);
      chk({31'h0, rst_out}, 32'h1);
      srst = 1'b1;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      repeat (5) @(negedge core_clk);
      st_rd(8'h00);
      stop_test();
   end
endmodule : tb_top
